// >>> peripheral_clock_gating_consts.vh
// Purpose: Constants for the peripheral clock gating block.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes:   Addresses are byte addresses on the APB.
`ifndef PERIPHERAL_CLOCK_GATING_CONSTS_VH
`define PERIPHERAL_CLOCK_GATING_CONSTS_VH

`define CG_PRIMARY_ADDR      32'hD003001C
`define CG_SECONDARY_ADDR    32'hD00300CC
`define CG_PRIMARY_RESET     32'hFFEDD5FF
`define CG_SECONDARY_RESET   32'hFFFFFF3E

// Writable bits; all other bits are reserved and hold their reset value.
`define CG_PRIMARY_WMASK     32'h7FFFFFFF
`define CG_SECONDARY_WMASK   32'h000000F7

`define CG_PRIMARY_BITS      31
`define CG_SECONDARY_BITS    8

`define CG_BIT_BSM           6
`define CG_BIT_FAST_COEF     16
`define CG_BIT_VLD           18
`define CG_BIT_SEQUENCER     26
`define CG_BIT_SYSTEM        6
`define CG_BIT_SLOW_COEF     7

`define CG_ZERO_WORD         32'h00000000

`endif

// >>> gate_enable_cell.v
// Purpose: One registered clock-run enable for a downstream clock gate.
// Assumes: The enable is consumed by a latch-based gate cell on core_clk.
// Notes:   Changing only at a rising edge keeps the gated clock free of runt pulses.
`timescale 1ns/1ps
module gate_enable_cell #(
  parameter RESET_EN = 1'b0
) (
  input  wire core_clk,
  input  wire arst_n,
  input  wire run_d,
  output reg  run_q
);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= RESET_EN;
    end else begin
      run_q <= run_d;
    end
  end

endmodule

// >>> peripheral_clock_gating.v
// Purpose: Software-controlled clock gating for the internal blocks, reached over APB.
// Assumes: One clock core_clk at 100 MHz; APB master keeps psel, paddr, pwrite, pwdata stable.
// Notes:   Each clock enable output is registered and high while the block's clock runs; prdata, pready and pslverr are APB outputs.
// Summary of operation
// [RQ1] Each block or clock group has one writable bit; 1 stops its clock and 0 lets it run.
// [RQ2] A block whose clock is stopped is disabled and does nothing until its bit is cleared.
// [RQ3] The primary register uses bits 30 to 0 per peripheral, bit 31 is reserved at one.
// [RQ4] Primary bit 26 stops both the stream buffers and the variable-length decoding clocks.
// [RQ5] Primary bit 6 stops the bitstream manager but leaves its decoding circuitry running.
// [RQ6] Primary bit 16 stops the high-speed clock of the coefficient memory.
// [RQ7] Secondary bit 7 stops the low-speed clock of the coefficient-memory interface.
// [RQ8] Secondary bit 6 stops boot loader, keypad, pulse-width modulator and GPIO together.
// [RQ9] The secondary register gates with bits 7 to 0; bits 31 to 8 and 3 are reserved.
// [RQ10] Reads return the last written value (the code reads reserved bits back at their reset value of one) and each gate changes without clipping pulses.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "peripheral_clock_gating_consts.vh"
module peripheral_clock_gating (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output wire [30:0] periph_clk_en,
  output wire [7:0]  system_clk_en,
  output wire        fast_coef_mem_clk_en,
  output wire        slow_coef_mem_clk_en,
  output wire        stream_buffers_clk_en,
  output wire        vld_decode_clk_en,
  output wire        boot_loader_clk_en,
  output wire        keypad_clk_en,
  output wire        pwm_clk_en,
  output wire        gpio_clk_en
);

  reg  [31:0] clock_gate_primary_q;
  reg  [31:0] clock_gate_secondary_q;
  wire        hit_primary;
  wire        hit_secondary;
  wire        access;
  wire        commit;
  reg  [31:0] rdata_d;

  localparam [31:0] PRIM_RESET = `CG_PRIMARY_RESET;
  localparam [31:0] SEC_RESET  = `CG_SECONDARY_RESET;

  assign hit_primary   = (paddr == `CG_PRIMARY_ADDR);
  assign hit_secondary = (paddr == `CG_SECONDARY_ADDR);
  assign access        = psel && penable;
  // The write lands at the edge where the master samples pready high.
  assign commit        = access && pready;

  // One wait state: pready rises one cycle into the access phase, then drops.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `CG_ZERO_WORD;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      pslverr <= !(hit_primary || hit_secondary);
      prdata  <= pwrite ? `CG_ZERO_WORD : rdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `CG_ZERO_WORD;
    end
  end

  // Read data is the stored word, reserved bits included.
  always @* begin
    if (hit_primary) begin
      rdata_d = clock_gate_primary_q; // see [RQ10]
    end else if (hit_secondary) begin
      rdata_d = clock_gate_secondary_q; // see [RQ10]
    end else begin
      rdata_d = `CG_ZERO_WORD;
    end
  end

  // Reserved bits are not writable and keep their reset value of one.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_gate_primary_q   <= `CG_PRIMARY_RESET; // see [RQ3]
      clock_gate_secondary_q <= `CG_SECONDARY_RESET; // see [RQ9]
    end else if (commit && pwrite) begin
      if (hit_primary) begin
        clock_gate_primary_q <= (pwdata & `CG_PRIMARY_WMASK) |
                                (`CG_PRIMARY_RESET & ~`CG_PRIMARY_WMASK); // see [RQ3]
      end
      if (hit_secondary) begin
        clock_gate_secondary_q <= (pwdata & `CG_SECONDARY_WMASK) |
                                  (`CG_SECONDARY_RESET & ~`CG_SECONDARY_WMASK); // see [RQ9]
      end
    end
  end

  // A set bit drops the block's run enable, so its clock stops and it is disabled.
  genvar i;
  generate
    for (i = 0; i < `CG_PRIMARY_BITS; i = i + 1) begin : g_prim
      gate_enable_cell #(.RESET_EN(~PRIM_RESET[i])) u_cell (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run_d    (~clock_gate_primary_q[i]), // see [RQ1] [RQ2] [RQ10]
        .run_q    (periph_clk_en[i])
      );
    end
    for (i = 0; i < `CG_SECONDARY_BITS; i = i + 1) begin : g_sec
      gate_enable_cell #(.RESET_EN(~SEC_RESET[i])) u_cell (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run_d    (~clock_gate_secondary_q[i]), // see [RQ1] [RQ9]
        .run_q    (system_clk_en[i])
      );
    end
  endgenerate

  gate_enable_cell #(.RESET_EN(~PRIM_RESET[`CG_BIT_FAST_COEF])) u_fast_coef (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_primary_q[`CG_BIT_FAST_COEF]), // see [RQ6]
    .run_q    (fast_coef_mem_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~SEC_RESET[`CG_BIT_SLOW_COEF])) u_slow_coef (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_secondary_q[`CG_BIT_SLOW_COEF]), // see [RQ7]
    .run_q    (slow_coef_mem_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~PRIM_RESET[`CG_BIT_SEQUENCER])) u_stream_buf (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_primary_q[`CG_BIT_SEQUENCER]), // see [RQ4]
    .run_q    (stream_buffers_clk_en)
  );

  // Decoding circuitry ignores the bitstream manager bit and follows only the sequencer bit.
  gate_enable_cell #(.RESET_EN(~PRIM_RESET[`CG_BIT_SEQUENCER])) u_vld_decode (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_primary_q[`CG_BIT_SEQUENCER]), // see [RQ4] [RQ5]
    .run_q    (vld_decode_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~SEC_RESET[`CG_BIT_SYSTEM])) u_boot (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_secondary_q[`CG_BIT_SYSTEM]), // see [RQ8]
    .run_q    (boot_loader_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~SEC_RESET[`CG_BIT_SYSTEM])) u_keypad (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_secondary_q[`CG_BIT_SYSTEM]), // see [RQ8]
    .run_q    (keypad_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~SEC_RESET[`CG_BIT_SYSTEM])) u_pwm (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_secondary_q[`CG_BIT_SYSTEM]), // see [RQ8]
    .run_q    (pwm_clk_en)
  );

  gate_enable_cell #(.RESET_EN(~SEC_RESET[`CG_BIT_SYSTEM])) u_gpio (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run_d    (~clock_gate_secondary_q[`CG_BIT_SYSTEM]), // see [RQ8]
    .run_q    (gpio_clk_en)
  );

endmodule

// >>> pcg_sva.sv
// Purpose: Port assertions for the clock gating block.
// Assumes: One clock; arst_n is the only reset.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
module pcg_sva (
  input logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr,
  input logic [30:0] periph_clk_en,
  input logic [7:0] system_clk_en,
  input logic fast_coef_mem_clk_en, slow_coef_mem_clk_en, stream_buffers_clk_en,
  input logic vld_decode_clk_en, boot_loader_clk_en, keypad_clk_en, pwm_clk_en, gpio_clk_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  property p_ans; s_acc |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("no answer"); // Handshake
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone error"); // Error
  property p_chg;
    $changed({periph_clk_en, system_clk_en}) |-> $past(pready, 2) && $past(pwrite, 2);
  endproperty
  a_chg: assert property (p_chg) else $error("stray change"); // Gate
  property p_seq; {stream_buffers_clk_en, vld_decode_clk_en} == {2{periph_clk_en[26]}}; endproperty
  a_seq: assert property (p_seq) else $error("sequencer"); // Group
  property p_fast; fast_coef_mem_clk_en == periph_clk_en[16]; endproperty
  a_fast: assert property (p_fast) else $error("fast coef"); // Fast
  property p_slow; slow_coef_mem_clk_en == system_clk_en[7]; endproperty
  a_slow: assert property (p_slow) else $error("slow coef"); // Slow
  property p_grp;
    {boot_loader_clk_en, keypad_clk_en, pwm_clk_en, gpio_clk_en} == {4{system_clk_en[6]}};
  endproperty
  a_grp: assert property (p_grp) else $error("system group"); // Group
  property p_rsv; !system_clk_en[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved"); // Reserved
endmodule
bind peripheral_clock_gating pcg_sva u_sva (.*);

// >>> tb.sv
// Purpose: Directed APB tests of the clock gating block.
// Assumes: One idle cycle between transfers.
// Notes:   Enables follow a write by one cycle.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'h0;
  logic arst_n, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, rd;
  wire [31:0] prdata;
  wire [30:0] periph_clk_en;
  wire [7:0] system_clk_en;
  wire pready, pslverr, fast_coef_mem_clk_en, slow_coef_mem_clk_en, stream_buffers_clk_en;
  wire vld_decode_clk_en, boot_loader_clk_en, keypad_clk_en, pwm_clk_en, gpio_clk_en;
  wire [7:0] grp = {stream_buffers_clk_en, vld_decode_clk_en, fast_coef_mem_clk_en,
    slow_coef_mem_clk_en, boot_loader_clk_en, keypad_clk_en, pwm_clk_en, gpio_clk_en};
  int n_fail = 0;
  int tests_run = 0;
  peripheral_clock_gating u_dut (.*);
  initial forever #5 core_clk = ~core_clk;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge, takes the answer there.
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // Writes a register, checks enables and group gates, then reads it back.
  task wc(input logic sec, input logic [31:0] d, input logic [7:0] g);
    logic [31:0] a, m;
    a = sec ? 32'hD00300CC : 32'hD003001C;
    m = sec ? 32'hFFFFFF08 : 32'h80000000;
    apb(1'h1, a, d);
    repeat (2) @(negedge core_clk);
    chk("en", sec ? {24'h0, system_clk_en} : {1'h0, periph_clk_en}, ~(d | m)); // Gate
    chk("grp", {24'h0, grp}, {24'h0, g}); // Groups
    apb(1'h0, a, 32'h0);
    chk("rd", rd, d | m); // Readback
  endtask
  task stop_test;
    $display("Checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    stop_test();
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = 68'h0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'h1;
    @(negedge core_clk);
    chk("en", {1'h0, periph_clk_en}, 32'h00122A00); // Reset
    chk("grp", {16'h0, system_clk_en, grp}, 32'h0000C11F); // Reset
    apb(1'h0, 32'hD003001C, 32'h0);
    chk("pri", rd, 32'hFFEDD5FF); // Reset
    apb(1'h0, 32'hD00300CC, 32'h0);
    chk("sec", rd, 32'hFFFFFF3E); // Reset
    wc(1'h0, 32'h0, 8'hFF); // All run
    wc(1'h0, 32'h00000040, 8'hFF); // Manager
    wc(1'h0, 32'h04000000, 8'h3F); // Sequencer
    wc(1'h0, 32'h00010000, 8'hDF); // Fast
    wc(1'h0, 32'hFFFFFFFF, 8'h1F); // All off
    wc(1'h1, 32'h0, 8'h1F); // All run
    wc(1'h1, 32'h00000040, 8'h10); // System
    wc(1'h1, 32'h00000080, 8'h0F); // Slow
    wc(1'h1, 32'hFFFFFFFF, 8'h00); // All off
    apb(1'h1, 32'hD0030020, 32'h0);
    chk("err", {31'h0, err}, 32'h1); // Unmapped
    apb(1'h0, 32'hD003001C, 32'h0);
    chk("pri", rd, 32'hFFFFFFFF); // Kept
    stop_test();
  end
endmodule
